// ===== common/p2e_regs.vh
`ifndef P2E_REGS_VH
`define P2E_REGS_VH

// Register byte addresses
`define P2E_ADDR_STATUS 11'h0f0
`define P2E_ADDR_RECOVERY 11'h0f2

// Status register field positions
`define P2E_BIT_RSVD15 15
`define P2E_BIT_HW_EEE_EN 14
`define P2E_BIT_TX_LPI_SEEN 13
`define P2E_BIT_TX_LPI_LIVE 12
`define P2E_BIT_RX_LPI_SEEN 11
`define P2E_BIT_RX_LPI_LIVE 10
`define P2E_BIT_RSVD9 9
`define P2E_BIT_RSVD8 8
`define P2E_BIT_NP_LOC_ABLE 6
`define P2E_BIT_NP_LOC 5
`define P2E_BIT_PD_FAULT 4
`define P2E_BIT_LP_NP_ABLE 3
`define P2E_BIT_NP_ABLE 2
`define P2E_BIT_PAGE_RX 1
`define P2E_BIT_LP_AN_ABLE 0

// Reset values
`define P2E_RST_RSVD15 1'b1
`define P2E_RST_RSVD98 2'h0
`define P2E_RST_NP_LOC_ABLE 1'b1
`define P2E_RST_NP_LOC 1'b1
`define P2E_RST_NP_ABLE 1'b1
`define P2E_RST_RECOVERY 8'h27

// Timing: one recovery unit in ns, system clock period in ns
`define P2E_RECOVERY_UNIT_NS 640
`define P2E_CLK_PERIOD_NS 4
`define P2E_UNIT_CYCLES (`P2E_RECOVERY_UNIT_NS / `P2E_CLK_PERIOD_NS)

`endif

// ===== core/p2e_recovery_timer.v
`timescale 1ns/1ps
`default_nettype none

module p2e_recovery_timer
#(
   parameter CNT_W = 8,
   parameter UNIT_CYCLES = 160
)
(
   // Clock and reset
   input wire i_clk_sys,
   input wire i_sys_rst,
   // Control
   input wire i_enable,
   input wire i_lpi_active,
   input wire [CNT_W-1:0] i_wait_units,
   // Status
   output reg o_hold
);

   localparam UW = (UNIT_CYCLES > 1) ? $clog2(UNIT_CYCLES) : 1;
   localparam integer UNIT_LAST_I = UNIT_CYCLES - 1;
   localparam [UW-1:0] UNIT_LAST = UNIT_LAST_I[UW-1:0];

   reg lpi_d_r;
   reg [CNT_W-1:0] units_left_r;
   reg [UW-1:0] unit_cnt_r;
   wire lpi_exit;

   assign lpi_exit = lpi_d_r & ~i_lpi_active;

   always @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         lpi_d_r <= 1'b0;
         units_left_r <= {CNT_W{1'b0}};
         unit_cnt_r <= {UW{1'b0}};
         o_hold <= 1'b0;
      end
      else if (!i_enable)
      begin
         // Fiber mode: no LPI, so nothing to recover from
         lpi_d_r <= 1'b0;
         units_left_r <= {CNT_W{1'b0}};
         unit_cnt_r <= {UW{1'b0}};
         o_hold <= 1'b0;
      end
      else
      begin
         lpi_d_r <= i_lpi_active;
         if (i_lpi_active)
         begin
            // Re-entering LPI abandons any wait in progress
            units_left_r <= {CNT_W{1'b0}};
            unit_cnt_r <= {UW{1'b0}};
            o_hold <= 1'b1;
         end
         else if (lpi_exit)
         begin
            units_left_r <= i_wait_units; // RULE_14
            unit_cnt_r <= {UW{1'b0}};
            o_hold <= (i_wait_units != {CNT_W{1'b0}});
         end
         else if (units_left_r != {CNT_W{1'b0}})
         begin
            if (unit_cnt_r == UNIT_LAST)
            begin
               unit_cnt_r <= {UW{1'b0}};
               units_left_r <= units_left_r - {{(CNT_W-1){1'b0}}, 1'b1}; // RULE_15
               o_hold <= (units_left_r != {{(CNT_W-1){1'b0}}, 1'b1});
            end
            else
            begin
               unit_cnt_r <= unit_cnt_r + {{(UW-1){1'b0}}, 1'b1};
            end
         end
         else
         begin
            o_hold <= 1'b0;
         end
      end
   end

endmodule // p2e_recovery_timer

`default_nettype wire

// ===== core/p2e_status_regs.v
// Summary of operation
// RULE_01: Read-only bit shows 1 when hardware next-page exchange enabled 100BASE-TX EEE.
// RULE_02: Sticky bit sets when transmit PCS has seen low power idle.
// RULE_03: Sticky LPI bits stay set until software writes one to them.
// RULE_04: Live bit follows transmit PCS low power idle, unlatched.
// RULE_05: Sticky bit sets when receive PCS has seen low power idle.
// RULE_06: Live bit follows receive PCS low power idle, unlatched.
// RULE_07: Read-only bit, default 1, says storage location is given by next bit.
// RULE_08: Read-only bit, default 1, says partner next pages go to dedicated register.
// RULE_09: Parallel detection fault latches high and clears when read.
// RULE_10: Read-only bit shows partner advertised next page capability.
// RULE_11: Read-only bit, default 1, shows local next page capability.
// RULE_12: Page received flag latches high on new partner page until cleared.
// RULE_13: Read-only bit shows partner auto-negotiation capability.
// RULE_14: MAC waits programmed 8-bit count after LPI; count resets to 0x27.
// RULE_15: Each recovery count unit is 640 ns of wait.
// RULE_16: Software programs count to larger of local and remote recovery times.
// RULE_17: EEE status and LPI functions are idle in fiber mode.
// RULE_18: Next-page enable control gates next-page exchange and EEE negotiation.
// RULE_19: Writes to read-only bits and zero writes to sticky bits change nothing.
`timescale 1ns/1ps
`default_nettype none
`include "p2e_regs.vh"

module p2e_status_regs
#(
   parameter ADDR_W = 11,
   parameter RECOVERY_W = 8,
   parameter UNIT_CYCLES = `P2E_UNIT_CYCLES
)
(
   // Clock and reset
   input wire i_clk_sys,
   input wire i_sys_rst,
   // Host register port
   input wire [ADDR_W-1:0] i_reg_addr,
   input wire [1:0] i_reg_be,
   input wire i_reg_wr,
   input wire i_reg_rd,
   input wire [15:0] i_reg_wdata,
   output reg [15:0] o_reg_rdata,
   output reg o_reg_ack,
   // Port mode and next-page control
   input wire i_fiber_mode,
   input wire i_np_enable,
   // PCS low power idle status
   input wire i_tx_lpi,
   input wire i_rx_lpi,
   // Auto-negotiation results
   input wire i_an_eee_resolved,
   input wire i_pd_fault,
   input wire i_page_rx,
   input wire i_lp_np_able,
   input wire i_lp_an_able,
   // Outputs to PHY and MAC
   output reg o_np_exchange_en,
   output wire o_mac_tx_hold,
   output reg o_eee_active
);

   // Word addresses; bit 0 of the byte address is ignored, i_reg_be picks the lane
   localparam [ADDR_W-1:0] STATUS_ADDR = `P2E_ADDR_STATUS;
   localparam [ADDR_W-1:0] RECOVERY_ADDR = `P2E_ADDR_RECOVERY;

   reg rsvd15_r;
   reg [1:0] rsvd98_r;
   reg pd_fault_r;
   reg page_rx_r;
   reg hw_eee_en_r;
   reg lp_np_able_r;
   reg lp_an_able_r;
   reg [RECOVERY_W-1:0] recovery_r;

   reg pd_fault_nxt;
   reg page_rx_nxt;
   reg [15:0] status_word;
   reg [15:0] rdata_nxt;

   wire copper;
   wire hit_status;
   wire hit_recovery;
   wire wr_status_hi;
   wire wr_recovery;
   wire rd_status_lo;
   wire tx_lpi_q;
   wire rx_lpi_q;
   wire [1:0] lpi_q;
   wire [1:0] lpi_clr;
   wire [1:0] lpi_seen;
   wire [1:0] lpi_live;

   assign copper = ~i_fiber_mode;
   assign hit_status = (i_reg_addr[ADDR_W-1:1] == STATUS_ADDR[ADDR_W-1:1]);
   assign hit_recovery = (i_reg_addr[ADDR_W-1:1] == RECOVERY_ADDR[ADDR_W-1:1]);
   assign wr_status_hi = i_reg_wr & hit_status & i_reg_be[1];
   assign wr_recovery = i_reg_wr & hit_recovery & i_reg_be[0];
   // Only a read that returns the low byte clears the latched events
   assign rd_status_lo = i_reg_rd & hit_status & i_reg_be[0];

   // LPI is meaningless on fiber; masking here keeps every consumer quiet
   assign tx_lpi_q = i_tx_lpi & copper; // RULE_17
   assign rx_lpi_q = i_rx_lpi & copper; // RULE_17
   assign lpi_q = {tx_lpi_q, rx_lpi_q};

   // Write-one-to-clear for the sticky bits; a zero leaves them alone
   assign lpi_clr[1] = wr_status_hi & i_reg_wdata[`P2E_BIT_TX_LPI_SEEN]; // RULE_03
   assign lpi_clr[0] = wr_status_hi & i_reg_wdata[`P2E_BIT_RX_LPI_SEEN]; // RULE_03

   // Read-to-clear flags; an event in the clearing cycle wins
   always @*
   begin
      pd_fault_nxt = pd_fault_r;
      page_rx_nxt = page_rx_r;
      if (rd_status_lo)
      begin
         pd_fault_nxt = 1'b0; // RULE_09
         page_rx_nxt = 1'b0; // RULE_12
      end
      if (i_pd_fault)
      begin
         pd_fault_nxt = 1'b1; // RULE_09
      end
      if (i_page_rx)
      begin
         page_rx_nxt = 1'b1; // RULE_12
      end
   end

   always @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         pd_fault_r <= 1'b0;
         page_rx_r <= 1'b0;
      end
      else
      begin
         pd_fault_r <= pd_fault_nxt;
         page_rx_r <= page_rx_nxt;
      end
   end

   // One lane per PCS direction: [1] transmit, [0] receive
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : g_lpi
         reg seen_r;
         reg live_r;
         always @(posedge i_clk_sys or posedge i_sys_rst)
         begin
            if (i_sys_rst)
            begin
               seen_r <= 1'b0;
            end
            else if (lpi_q[g])
            begin
               // Set beats a same-cycle clear, so no LPI episode is lost
               seen_r <= 1'b1; // RULE_02 RULE_05
            end
            else if (lpi_clr[g])
            begin
               seen_r <= 1'b0; // RULE_03
            end
         end

         always @(posedge i_clk_sys or posedge i_sys_rst)
         begin
            if (i_sys_rst)
            begin
               live_r <= 1'b0;
            end
            else
            begin
               live_r <= lpi_q[g]; // RULE_04 RULE_06
            end
         end
         assign lpi_seen[g] = seen_r;
         assign lpi_live[g] = live_r;
      end
   endgenerate

   // Live and negotiated status snapshots
   always @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         hw_eee_en_r <= 1'b0;
         lp_np_able_r <= 1'b0;
         lp_an_able_r <= 1'b0;
         o_np_exchange_en <= 1'b0;
         o_eee_active <= 1'b0;
      end
      else
      begin
         // Without next-page exchange there is no EEE resolution to report
         hw_eee_en_r <= i_an_eee_resolved & i_np_enable & copper; // RULE_01 RULE_18
         lp_np_able_r <= i_lp_np_able; // RULE_10
         lp_an_able_r <= i_lp_an_able; // RULE_13
         o_np_exchange_en <= i_np_enable; // RULE_18
         // Either direction in LPI means EEE is in use
         o_eee_active <= tx_lpi_q | rx_lpi_q;
      end
   end

   // Writable fields; read-only bits have no write path at all
   always @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         rsvd15_r <= `P2E_RST_RSVD15;
         rsvd98_r <= `P2E_RST_RSVD98;
         recovery_r <= `P2E_RST_RECOVERY; // RULE_14
      end
      else
      begin
         if (wr_status_hi)
         begin
            rsvd15_r <= i_reg_wdata[`P2E_BIT_RSVD15];
            rsvd98_r <= i_reg_wdata[`P2E_BIT_RSVD9:`P2E_BIT_RSVD8]; // RULE_19
         end
         if (wr_recovery)
         begin
            recovery_r <= i_reg_wdata[RECOVERY_W-1:0]; // RULE_14
         end
      end
   end

   // Register image as software sees it
   always @*
   begin
      status_word = 16'h0000;
      status_word[`P2E_BIT_RSVD15] = rsvd15_r;
      status_word[`P2E_BIT_HW_EEE_EN] = hw_eee_en_r; // RULE_01
      status_word[`P2E_BIT_TX_LPI_SEEN] = lpi_seen[1];
      status_word[`P2E_BIT_TX_LPI_LIVE] = lpi_live[1];
      status_word[`P2E_BIT_RX_LPI_SEEN] = lpi_seen[0];
      status_word[`P2E_BIT_RX_LPI_LIVE] = lpi_live[0];
      status_word[`P2E_BIT_RSVD9:`P2E_BIT_RSVD8] = rsvd98_r;
      status_word[`P2E_BIT_NP_LOC_ABLE] = `P2E_RST_NP_LOC_ABLE; // RULE_07
      status_word[`P2E_BIT_NP_LOC] = `P2E_RST_NP_LOC; // RULE_08
      status_word[`P2E_BIT_PD_FAULT] = pd_fault_r;
      status_word[`P2E_BIT_LP_NP_ABLE] = lp_np_able_r;
      status_word[`P2E_BIT_NP_ABLE] = `P2E_RST_NP_ABLE; // RULE_11
      status_word[`P2E_BIT_PAGE_RX] = page_rx_r;
      status_word[`P2E_BIT_LP_AN_ABLE] = lp_an_able_r;
   end

   // Unmapped addresses and unselected lanes read as zero
   always @*
   begin
      rdata_nxt = 16'h0000;
      if (hit_status)
      begin
         rdata_nxt[7:0] = i_reg_be[0] ? status_word[7:0] : 8'h00;
         rdata_nxt[15:8] = i_reg_be[1] ? status_word[15:8] : 8'h00;
      end
      // High lane of the count word has no storage
      else if (hit_recovery && i_reg_be[0])
      begin
         rdata_nxt[RECOVERY_W-1:0] = recovery_r;
      end
   end

   // Read data is captured before the clear-on-read takes effect
   always @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_reg_rdata <= 16'h0000;
         o_reg_ack <= 1'b0;
      end
      else
      begin
         // Every strobe is answered, mapped or not, so the host never waits
         o_reg_ack <= i_reg_rd | i_reg_wr;
         if (i_reg_rd)
         begin
            o_reg_rdata <= rdata_nxt;
         end
      end
   end

   p2e_recovery_timer
   #(
      .CNT_W(RECOVERY_W),
      .UNIT_CYCLES(UNIT_CYCLES)
   )
   u_recovery
   (
      .i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst),
      .i_enable(copper), // RULE_17
      // Only transmit LPI holds the MAC back
      .i_lpi_active(tx_lpi_q),
      .i_wait_units(recovery_r), // RULE_14 RULE_15
      .o_hold(o_mac_tx_hold)
   );

endmodule // p2e_status_regs

`default_nettype wire

// ===== sim/p2e_link_partner.sv
`timescale 1ns/1ps
`default_nettype none
module p2e_link_partner
(
   // Clock
   input wire logic i_clk_sys,
   // PCS and negotiation status seen by the port
   output logic o_tx_lpi,
   output logic o_rx_lpi,
   output logic o_an_eee_resolved,
   output logic o_pd_fault,
   output logic o_page_rx,
   output logic o_lp_np_able,
   output logic o_lp_an_able
);
   initial {o_tx_lpi, o_rx_lpi, o_an_eee_resolved, o_pd_fault, o_page_rx} = 5'h0;
   initial {o_lp_np_able, o_lp_an_able} = 2'h0;
   // Order: tx lpi, rx lpi, eee resolved, partner next page, partner autoneg
   task automatic set_levels(input logic [4:0] v);
      @(posedge i_clk_sys) #1;
      o_tx_lpi = v[4];
      o_rx_lpi = v[3];
      o_an_eee_resolved = v[2];
      o_lp_np_able = v[1];
      o_lp_an_able = v[0];
   endtask
   // One-cycle events, so only a latch can keep them
   task automatic pulse_events();
      @(posedge i_clk_sys) #1;
      o_pd_fault = 1'b1;
      o_page_rx = 1'b1;
      @(posedge i_clk_sys) #1;
      o_pd_fault = 1'b0;
      o_page_rx = 1'b0;
   endtask
endmodule // p2e_link_partner
`default_nettype wire

// ===== sim/p2e_status_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module p2e_status_regs_props
#(
   parameter UNIT_CYCLES = 160
)
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   // Host register port
   input wire logic [10:0] i_reg_addr,
   input wire logic [1:0] i_reg_be,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [15:0] i_reg_wdata,
   input wire logic [15:0] o_reg_rdata,
   input wire logic o_reg_ack,
   // Status inputs and outputs
   input wire logic i_fiber_mode,
   input wire logic i_np_enable,
   input wire logic i_tx_lpi,
   input wire logic i_rx_lpi,
   input wire logic i_an_eee_resolved,
   input wire logic i_pd_fault,
   input wire logic i_page_rx,
   input wire logic i_lp_np_able,
   input wire logic i_lp_an_able,
   input wire logic o_np_exchange_en,
   input wire logic o_mac_tx_hold,
   input wire logic o_eee_active
);
   logic [7:0] cnt_r;
   logic [15:0] len_r;
   wire logic rd_stat = i_reg_rd && i_reg_addr[10:1] == 10'h078 && i_reg_be == 2'h3;
   // Mirror of the count and the length of each hold tail
   always_ff @(posedge i_clk_sys or posedge i_sys_rst)
      if (i_sys_rst)
      begin
         cnt_r <= 8'h27;
         len_r <= 16'h0;
      end
      else
      begin
         if (i_reg_wr && i_reg_addr[10:1] == 10'h079 && i_reg_be[0])
            cnt_r <= i_reg_wdata[7:0];
         if (i_tx_lpi && !i_fiber_mode)
            len_r <= 16'h0;
         else if (o_mac_tx_hold)
            len_r <= len_r + 16'h1;
      end
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   AST_NP_EN: assert property (1 |=> o_np_exchange_en == $past(i_np_enable))
      else $error("next page enable copy wrong");
   AST_EEE_ACTIVE: assert property (1 |=> o_eee_active ==
      $past((i_tx_lpi || i_rx_lpi) && !i_fiber_mode)) else $error("eee active wrong");
   AST_LIVE: assert property (rd_stat && !$past(i_sys_rst) |=>
      o_reg_rdata[12] == $past(i_tx_lpi && !i_fiber_mode, 2) &&
      o_reg_rdata[10] == $past(i_rx_lpi && !i_fiber_mode, 2)) else $error("live lpi wrong");
   AST_EEE_EN: assert property (rd_stat && !$past(i_sys_rst) |=> o_reg_rdata[14] ==
      $past(i_an_eee_resolved && i_np_enable && !i_fiber_mode, 2)) else $error("eee bit wrong");
   AST_CONST: assert property (rd_stat |=> o_reg_rdata[7:5] == 3'h3 && o_reg_rdata[2])
      else $error("constant bits wrong");
   AST_HOLD_LPI: assert property ((i_tx_lpi && !i_fiber_mode) ##1 !i_fiber_mode |->
      o_mac_tx_hold) else $error("hold missing after lpi");
   AST_HOLD_LEN: assert property ($fell(o_mac_tx_hold) && !$past(i_fiber_mode) |->
      len_r == cnt_r * UNIT_CYCLES + 1) else $error("hold length wrong");
   AST_FIBER_HOLD: assert property (i_fiber_mode |=> !o_mac_tx_hold)
      else $error("hold in fiber mode");
   cover property (rd_stat);
   cover property ($fell(o_mac_tx_hold));
   cover property (i_tx_lpi && i_fiber_mode);
endmodule // p2e_status_regs_props
bind p2e_status_regs p2e_status_regs_props #(.UNIT_CYCLES(UNIT_CYCLES)) i_props (.*);
`default_nettype wire

// ===== sim/p2e_status_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module p2e_status_regs_bench;
   localparam int UNIT = 4;
   logic i_clk_sys = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [10:0] i_reg_addr = 11'h0;
   logic [1:0] i_reg_be = 2'h0;
   logic i_reg_wr = 1'b0;
   logic i_reg_rd = 1'b0;
   logic [15:0] i_reg_wdata = 16'h0;
   logic i_fiber_mode = 1'b0;
   logic i_np_enable = 1'b1;
   wire logic tx, rx, eee, pd, pg, lpnp, lpan, ack, np_out, hold, active;
   wire logic [15:0] rdata;
   logic [29:0] rows [0:12];
   logic [7:0] cnt [0:2] = '{8'h00, 8'h02, 8'hff};
   logic [15:0] rd;
   int mismatches = 0;
   int tests_run = 0;
   int n;
   always #2 i_clk_sys = ~i_clk_sys;
   p2e_status_regs #(.UNIT_CYCLES(UNIT)) i_p2e_status_regs (.i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr), .i_reg_be(i_reg_be),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
      .o_reg_rdata(rdata), .o_reg_ack(ack), .i_fiber_mode(i_fiber_mode),
      .i_np_enable(i_np_enable), .i_tx_lpi(tx), .i_rx_lpi(rx), .i_an_eee_resolved(eee),
      .i_pd_fault(pd), .i_page_rx(pg), .i_lp_np_able(lpnp), .i_lp_an_able(lpan),
      .o_np_exchange_en(np_out), .o_mac_tx_hold(hold), .o_eee_active(active));
   p2e_link_partner i_p2e_link_partner (.i_clk_sys(i_clk_sys), .o_tx_lpi(tx), .o_rx_lpi(rx),
      .o_an_eee_resolved(eee), .o_pd_fault(pd), .o_page_rx(pg), .o_lp_np_able(lpnp),
      .o_lp_an_able(lpan));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic access(input logic wr, input logic [10:0] a, input logic [1:0] be,
      input logic [15:0] d);
      @(posedge i_clk_sys) #1;
      i_reg_wr = wr;
      i_reg_rd = !wr;
      i_reg_addr = a;
      i_reg_be = be;
      i_reg_wdata = d;
      @(posedge i_clk_sys) #1;
      i_reg_wr = 1'b0;
      i_reg_rd = 1'b0;
      rd = rdata;
      chk("ack", 16'h1, {15'h0, ack});
   endtask
   task automatic end_sim();
      if (mismatches == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      #40000;
      mismatches++;
      end_sim();
   end
   initial
   begin
      rows[0] = {1'b0, 11'h0f0, 2'h3, 16'h8064};
      rows[1] = {1'b0, 11'h0f2, 2'h3, 16'h0027};
      rows[2] = {1'b1, 11'h0f0, 2'h3, 16'h0000};
      rows[3] = {1'b0, 11'h0f0, 2'h3, 16'h0064};
      rows[4] = {1'b1, 11'h0f0, 2'h3, 16'hffff};
      rows[5] = {1'b0, 11'h0f0, 2'h3, 16'h8364};
      rows[6] = {1'b0, 11'h0f0, 2'h1, 16'h0064};
      rows[7] = {1'b1, 11'h0f2, 2'h1, 16'h0050};
      rows[8] = {1'b1, 11'h0f2, 2'h2, 16'h00ff};
      rows[9] = {1'b0, 11'h0f2, 2'h3, 16'h0050};
      rows[10] = {1'b1, 11'h0f4, 2'h3, 16'hffff};
      rows[11] = {1'b0, 11'h0f4, 2'h3, 16'h0000};
      rows[12] = {1'b1, 11'h0f2, 2'h1, 16'h0002};
      repeat (4) @(posedge i_clk_sys);
      #1 i_sys_rst = 1'b0;
      for (int i = 0; i < 13; i++)
      begin
         access(rows[i][29], rows[i][28:18], rows[i][17:16], rows[i][15:0]);
         if (!rows[i][29])
            chk("row", rows[i][15:0], rd);
      end
      for (int k = 0; k < 2; k++)
      begin
         i_p2e_link_partner.set_levels(k ? 5'h08 : 5'h10);
         access(1'b0, 11'h0f0, 2'h3, 16'h0);
         chk("lpi on", k ? 16'h0c00 : 16'h3000, rd & 16'h3c00);
         chk("active", 16'h1, {15'h0, active});
         i_p2e_link_partner.set_levels(5'h00);
         access(1'b1, 11'h0f0, 2'h2, 16'h0);
         access(1'b0, 11'h0f0, 2'h3, 16'h0);
         chk("lpi seen", k ? 16'h0800 : 16'h2000, rd & 16'h3c00);
         access(1'b1, 11'h0f0, 2'h2, 16'h2800);
         access(1'b0, 11'h0f0, 2'h3, 16'h0);
         chk("lpi cleared", 16'h0, rd & 16'h3c00);
      end
      for (int j = 0; j < 3; j++)
      begin
         access(1'b1, 11'h0f2, 2'h1, {8'h0, cnt[j]});
         i_p2e_link_partner.set_levels(5'h10);
         i_p2e_link_partner.set_levels(5'h00);
         n = 0;
         do
         begin
            @(posedge i_clk_sys) #1;
            n++;
         end
         while (hold === 1'b1 && n < 1100);
         chk("hold", 16'(cnt[j] * UNIT + 1), 16'(n));
      end
      // The hold scenarios left transmit LPI seen latched; clear it first
      access(1'b1, 11'h0f0, 2'h2, 16'h2800);
      i_fiber_mode = 1'b1;
      i_p2e_link_partner.set_levels(5'h1f);
      access(1'b0, 11'h0f0, 2'h3, 16'h0);
      chk("fiber", 16'h0, rd & 16'h7c00);
      chk("fiber hold", 16'h0, {14'h0, hold, active});
      // Drop lpi before leaving fiber, else a long hold tail starts
      i_p2e_link_partner.set_levels(5'h07);
      i_fiber_mode = 1'b0;
      access(1'b0, 11'h0f0, 2'h3, 16'h0);
      chk("an", 16'h4009, rd & 16'h4009);
      i_np_enable = 1'b0;
      access(1'b0, 11'h0f0, 2'h3, 16'h0);
      chk("np off", 16'h0009, rd & 16'h4009);
      chk("np out", 16'h0, {15'h0, np_out});
      i_np_enable = 1'b1;
      access(1'b0, 11'h0f0, 2'h3, 16'h0);
      chk("np on", 16'h4009, rd & 16'h4009);
      chk("np out on", 16'h1, {15'h0, np_out});
      i_p2e_link_partner.pulse_events();
      access(1'b0, 11'h0f0, 2'h2, 16'h0);
      access(1'b0, 11'h0f0, 2'h3, 16'h0);
      chk("latched", 16'h0012, rd & 16'h0012);
      access(1'b0, 11'h0f0, 2'h3, 16'h0);
      chk("read clears", 16'h0, rd & 16'h0012);
      i_p2e_link_partner.set_levels(5'h00);
      i_sys_rst = 1'b1;
      #1 chk("in reset", 16'h0, {13'h0, ack, hold, active});
      @(posedge i_clk_sys) #1 i_sys_rst = 1'b0;
      access(1'b0, 11'h0f0, 2'h3, 16'h0);
      chk("reset status", 16'h8064, rd);
      access(1'b0, 11'h0f2, 2'h3, 16'h0);
      chk("reset count", 16'h0027, rd);
      end_sim();
   end
endmodule // p2e_status_regs_bench
`default_nettype wire
